// >>> rtl/fsop_regs.vh
// constants for the fuse-programmed sum-of-products array
// assumes inclusion by bare name from rtl files
`ifndef FSOP_REGS_VH
`define FSOP_REGS_VH

// default array shape
`define FSOP_N_IN        8
`define FSOP_N_OUT       8
`define FSOP_N_PT        8
`define FSOP_ROW_W       6
`define FSOP_COL_W       4

// literal column layout: true at even column, inverted at odd
`define FSOP_LIT_TRUE    1'b0
`define FSOP_LIT_INV     1'b1

// fuse states
`define FSOP_FUSE_INTACT 1'b1
`define FSOP_FUSE_OPEN   1'b0

// number of security fuses and their blank value
`define FSOP_N_SEC       2
`define FSOP_SEC_BLANK   2'h0
`define FSOP_SEC_ALL     2'h3

// per-output defaults: all registered, all true polarity
`define FSOP_REG_MASK    8'hFF
`define FSOP_POL_MASK    8'hFF

// readback value while inhibited
`define FSOP_VFY_BLOCK   1'b0

`endif

// >>> rtl/fsop_cell.v
// one output slice: product terms, fixed OR, polarity and optional flip-flop
// assumes literals and fuse row already in the core_clk domain
`timescale 1ns/1ps
`include "fsop_regs.vh"

module fsop_cell #(
  parameter N_IN   = `FSOP_N_IN,
  parameter N_PT   = `FSOP_N_PT,
  parameter IS_REG = 1,
  parameter POL    = 1
) (
  input  wire                    core_clk,
  input  wire                    nrst,
  input  wire [2*N_IN-1:0]       lits,
  input  wire [N_PT*2*N_IN-1:0]  fuse_row,
  output wire                    dout
);

  // and of every literal whose link is intact
  function pterm;
    input [2*N_IN-1:0] l;
    input [2*N_IN-1:0] f;
    begin
      pterm = &(l | ~f);
    end
  endfunction

  reg  [N_PT-1:0] pt_v;
  reg             sum;
  wire            sum_pol;
  reg             q_r;
  integer         k;

  always @* begin
    pt_v = {N_PT{1'b0}};
    for (k = 0; k < N_PT; k = k + 1) begin
      pt_v[k] = pterm(lits, fuse_row[k*2*N_IN +: 2*N_IN]);
    end
    sum = |pt_v;
  end

  assign sum_pol = (POL != 0) ? sum : ~sum;

  // rising-edge capture only
  always @(posedge core_clk) begin
    if (!nrst) begin
      q_r <= 1'b0;
    end else begin
      q_r <= sum_pol;
    end
  end

  assign dout = (IS_REG != 0) ? q_r : sum_pol;

endmodule // fsop_cell

// >>> rtl/fsop_array.v
// top of the fuse-programmed sum-of-products array with fuse programming port
// assumes pin inputs are asynchronous; programming port is on core_clk
//
// Functional notes
// - each output is a fixed OR of several product terms, each an AND of chosen literals.
// - an intact link keeps its literal in the product term and an opened link drops it.
// - a product term with every link opened reads as one regardless of inputs.
// - a product term holding both true and inverted literal of one input reads as zero.
// - registered outputs load their sum only on the rising edge of the clock.
// - once the two security fuses are opened after programming, readback of the pattern is inhibited.
`timescale 1ns/1ps
`include "fsop_regs.vh"

module fsop_array #(
  parameter N_IN     = `FSOP_N_IN,
  parameter N_OUT    = `FSOP_N_OUT,
  parameter N_PT     = `FSOP_N_PT,
  parameter ROW_W    = `FSOP_ROW_W,
  parameter COL_W    = `FSOP_COL_W,
  parameter REG_MASK = `FSOP_REG_MASK,
  parameter POL_MASK = `FSOP_POL_MASK
) (
  input  wire              core_clk,
  input  wire              nrst,
  input  wire [N_IN-1:0]   pin_in,
  output wire [N_OUT-1:0]  pin_out,
  input  wire              prog_en,
  input  wire              blow_strb,
  input  wire [ROW_W-1:0]  blow_row,
  input  wire [COL_W-1:0]  blow_col,
  input  wire              sec_strb,
  input  wire              sec_idx,
  input  wire              vfy_strb,
  input  wire [ROW_W-1:0]  vfy_row,
  input  wire [COL_W-1:0]  vfy_col,
  output reg               vfy_valid_r,
  output reg               vfy_data_r,
  output wire              sec_lock
);

  localparam N_ROW = N_OUT * N_PT;
  localparam N_LIT = 2 * N_IN;

  // row/column range check, shared by blow and verify
  function addr_ok;
    input [ROW_W-1:0] r;
    input [COL_W-1:0] c;
    begin
      addr_ok = (r < N_ROW) && (c < N_LIT);
    end
  endfunction

  // two-stage pin synchroniser
  reg  [N_IN-1:0]     pin_s1_r;
  reg  [N_IN-1:0]     pin_s2_r;
  // fuse map, one row per product term
  reg  [N_LIT-1:0]    fuse_r [0:N_ROW-1];
  reg  [`FSOP_N_SEC-1:0] sec_r;
  reg  [N_LIT-1:0]    lits;
  integer             i;

  always @(posedge core_clk) begin
    if (!nrst) begin
      pin_s1_r <= {N_IN{1'b0}};
      pin_s2_r <= {N_IN{1'b0}};
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // true and inverted literal of each input
  always @* begin
    lits = {N_LIT{1'b0}};
    for (i = 0; i < N_IN; i = i + 1) begin
      lits[2*i]     = pin_s2_r[i];
      lits[2*i + 1] = ~pin_s2_r[i];
    end
  end

  // blank part at reset; blowing only opens links
  always @(posedge core_clk) begin
    if (!nrst) begin
      for (i = 0; i < N_ROW; i = i + 1) begin
        fuse_r[i] <= {N_LIT{`FSOP_FUSE_INTACT}};
      end
    end else if (prog_en && blow_strb && addr_ok(blow_row, blow_col)) begin
      fuse_r[blow_row][blow_col] <= `FSOP_FUSE_OPEN;
    end
  end

  // security fuses, one at a time, only while programming
  always @(posedge core_clk) begin
    if (!nrst) begin
      sec_r <= `FSOP_SEC_BLANK;
    end else if (prog_en && sec_strb) begin
      sec_r[sec_idx] <= 1'b1;
    end
  end

  assign sec_lock = (sec_r == `FSOP_SEC_ALL);

  // readback of one fuse, blocked once both security fuses are open
  always @(posedge core_clk) begin
    if (!nrst) begin
      vfy_valid_r <= 1'b0;
      vfy_data_r  <= 1'b0;
    end else begin
      vfy_valid_r <= prog_en && vfy_strb;
      if (prog_en && vfy_strb) begin
        if (sec_lock || !addr_ok(vfy_row, vfy_col)) begin
          vfy_data_r <= `FSOP_VFY_BLOCK;
        end else begin
          vfy_data_r <= fuse_r[vfy_row][vfy_col];
        end
      end
    end
  end

  // one slice per output
  genvar g;
  genvar p;
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : g_out
      wire [N_PT*N_LIT-1:0] row_bus;
      for (p = 0; p < N_PT; p = p + 1) begin : g_pt
        assign row_bus[p*N_LIT +: N_LIT] = fuse_r[g*N_PT + p];
      end
      fsop_cell #(
        .N_IN   (N_IN),
        .N_PT   (N_PT),
        .IS_REG ((REG_MASK >> g) & 1),
        .POL    ((POL_MASK >> g) & 1)
      ) u_cell (
        .core_clk (core_clk),
        .nrst     (nrst),
        .lits     (lits),
        .fuse_row (row_bus),
        .dout     (pin_out[g])
      );
    end
  endgenerate

endmodule // fsop_array

// >>> tb/fsop_array_monitor.sv
// checker on the ports of the sum-of-products array
// assumes bench shape: out0 inverted, last output never programmed
`timescale 1ns/1ps
module fsop_mon #(parameter N_IN = 8, parameter N_OUT = 8) (
  input wire              core_clk,
  input wire              nrst,
  input wire [N_IN-1:0]   pin_in,
  input wire [N_OUT-1:0]  pin_out,
  input wire              prog_en,
  input wire              vfy_strb,
  input wire              vfy_valid_r,
  input wire              vfy_data_r,
  input wire              sec_lock
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire req = prog_en && vfy_strb;
  vfy_pulse_a: assert property (req |=> vfy_valid_r) else $error("readback pulse missing");
  vfy_quiet_a: assert property (!req |=> !vfy_valid_r) else $error("readback pulse unasked");
  lock_block_a: assert property (req && sec_lock |=> !vfy_data_r) else $error("locked readback leaked");
  lock_hold_a: assert property (sec_lock |=> sec_lock) else $error("lock dropped");
  reset_clear_a: assert property (disable iff (1'b0) !nrst |=> !sec_lock && !vfy_valid_r)
    else $error("reset state wrong");
  pin_hold_a: assert property ((!prog_en && $stable(pin_in)) [*3] |=> $stable(pin_out))
    else $error("output moved without cause");
  blank_zero_a: assert property (pin_out[N_OUT-1] == 1'b0) else $error("blank output not zero");
  pol_inv_a: assert property (pin_out[0] == 1'b1) else $error("inverted blank not one");
  cover property (req && sec_lock);
  cover property (pin_out[2]);
  cover property (vfy_valid_r && vfy_data_r);
endmodule // fsop_mon

bind fsop_array fsop_mon #(.N_IN(N_IN), .N_OUT(N_OUT)) u_mon (.*);

// >>> tb/fsop_array_bench.sv
// self-checking bench for the sum-of-products array
// assumes default shape, output 0 combinational and inverted
`timescale 1ns/1ps
module fsop_array_bench;
  reg        core_clk = 0, nrst = 0, prog_en = 0, blow_strb = 0, sec_strb = 0, sec_idx = 0, vfy_strb = 0;
  reg  [7:0] pin_in = 8'h00;
  reg  [5:0] blow_row = 6'h00, vfy_row = 6'h00;
  reg  [3:0] blow_col = 4'h0, vfy_col = 4'h0;
  wire [7:0] pin_out;
  wire       vfy_valid_r, vfy_data_r, sec_lock;
  integer    err_total = 0, comparisons = 0, c;
  fsop_array #(.REG_MASK(8'hFE), .POL_MASK(8'hFE)) i_dut (.core_clk(core_clk), .nrst(nrst),
    .pin_in(pin_in), .pin_out(pin_out), .prog_en(prog_en), .blow_strb(blow_strb), .blow_row(blow_row),
    .blow_col(blow_col), .sec_strb(sec_strb), .sec_idx(sec_idx), .vfy_strb(vfy_strb), .vfy_row(vfy_row),
    .vfy_col(vfy_col), .vfy_valid_r(vfy_valid_r), .vfy_data_r(vfy_data_r), .sec_lock(sec_lock));
  initial forever #2.5 core_clk = ~core_clk;
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task blw(input [5:0] r, input integer lo, input integer hi);
    for (c = lo; c <= hi; c = c + 1) begin
      @(negedge core_clk) prog_en = 1;
      blow_strb = 1;
      blow_row = r;
      blow_col = c[3:0];
    end
    @(negedge core_clk) blow_strb = 0;
    prog_en = 0;
  endtask
  task vfy(input [5:0] r, input [3:0] cl, input logic d);
    @(negedge core_clk) prog_en = 1;
    vfy_strb = 1;
    vfy_row = r;
    vfy_col = cl;
    @(negedge core_clk) vfy_strb = 0;
    prog_en = 0;
    chk("readback", {7'h01, d}, {6'h00, vfy_valid_r, vfy_data_r});
  endtask
  task pin(input [7:0] v, input [7:0] e);
    @(negedge core_clk) pin_in = v;
    repeat (4) @(negedge core_clk);
    chk("pin_out", e, pin_out);
  endtask
  task t_reset;
    chk("blank", 8'h01, pin_out);
    chk("lock", 8'h00, {7'h00, sec_lock});
  endtask
  task t_terms;
    blw(6'h08, 0, 15);
    blw(6'h10, 1, 15);
    blw(6'h11, 0, 1);
    blw(6'h11, 3, 15);
    pin(8'h01, 8'h07);
    pin(8'h02, 8'h07);
    pin(8'h00, 8'h03);
    pin(8'h04, 8'h03);
    vfy(6'h08, 4'h0, 1'b0);
    vfy(6'h09, 4'h0, 1'b1);
  endtask
  task t_lock;
    @(negedge core_clk) prog_en = 1;
    sec_strb = 1;
    @(negedge core_clk) sec_idx = 1;
    chk("one fuse", 8'h00, {7'h00, sec_lock});
    @(negedge core_clk) sec_strb = 0;
    chk("both fuses", 8'h01, {7'h00, sec_lock});
    vfy(6'h09, 4'h0, 1'b0);
  endtask
  task results;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    err_total = err_total + 1;
    results;
  end
  initial begin
    repeat (8) @(negedge core_clk);
    nrst = 1;
    t_reset;
    t_terms;
    t_lock;
    results;
  end
endmodule // fsop_array_bench
